// ===== shared/phy_cfg_pkg.sv
/*
 * Register map, field layout and reset values of the PHY wake-pattern,
 * EEE and PCS configuration bank.
 * Assumes: 16-bit register port addressed by the printed register offset.
 */
package phy_cfg_pkg;

   // ************************************************
   // Widths and sizes
   // ************************************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int NUM_REGS = 10;
   localparam int IDX_W = 4;
   typedef logic [DATA_W-1:0] word_t;

   // ************************************************
   // Register offsets
   // ************************************************
   localparam word_t OFF_MASK_16_31 = 16'h04c9;
   localparam word_t OFF_MASK_32_47 = 16'h04ca;
   localparam word_t OFF_MASK_48_63 = 16'h04cb;
   localparam word_t OFF_CMP_START = 16'h04cc;
   localparam word_t OFF_EEE_TWO = 16'h04d0;
   localparam word_t OFF_EEE_THREE = 16'h04d1;
   localparam word_t OFF_LOOP_BW_ONE = 16'h04d4;
   localparam word_t OFF_LOOP_BW_TWO = 16'h04d5;
   localparam word_t OFF_LOOP_BW_THREE = 16'h04d6;
   localparam word_t OFF_PCS_CTRL_ONE = 16'h3000;

   // Storage index of each register
   localparam int IDX_MASK_16_31 = 0;
   localparam int IDX_MASK_32_47 = 1;
   localparam int IDX_MASK_48_63 = 2;
   localparam int IDX_CMP_START = 3;
   localparam int IDX_EEE_TWO = 4;
   localparam int IDX_EEE_THREE = 5;
   localparam int IDX_LOOP_BW_ONE = 6;
   localparam int IDX_LOOP_BW_TWO = 7;
   localparam int IDX_LOOP_BW_THREE = 8;
   localparam int IDX_PCS_CTRL_ONE = 9;

   // ************************************************
   // Reset values and writable bits
   // ************************************************
   localparam word_t RST_MASK = 16'h0000;
   localparam word_t RST_CMP_START = 16'h000c;
   localparam word_t RST_EEE_TWO = 16'h0302;
   localparam word_t RST_EEE_THREE = 16'h018b;
   localparam word_t RST_LOOP_BW_ONE = 16'h7220;
   localparam word_t RST_LOOP_BW_TWO = 16'hfbc1;
   localparam word_t RST_LOOP_BW_THREE = 16'h01c1;
   localparam word_t RST_PCS_CTRL_ONE = 16'h0400;

   localparam word_t WM_FULL = 16'hffff;
   localparam word_t WM_CMP_START = 16'h003f;
   localparam word_t WM_EEE_TWO = 16'h4060;
   localparam word_t WM_PCS_CTRL_ONE = 16'h0400;

   localparam word_t REG_OFFS [NUM_REGS] = '{OFF_MASK_16_31,
      OFF_MASK_32_47, OFF_MASK_48_63, OFF_CMP_START, OFF_EEE_TWO,
      OFF_EEE_THREE, OFF_LOOP_BW_ONE, OFF_LOOP_BW_TWO,
      OFF_LOOP_BW_THREE, OFF_PCS_CTRL_ONE};
   localparam word_t REG_RSTS [NUM_REGS] = '{RST_MASK, RST_MASK,
      RST_MASK, RST_CMP_START, RST_EEE_TWO, RST_EEE_THREE,
      RST_LOOP_BW_ONE, RST_LOOP_BW_TWO, RST_LOOP_BW_THREE,
      RST_PCS_CTRL_ONE};
   localparam word_t REG_WMS [NUM_REGS] = '{WM_FULL, WM_FULL, WM_FULL,
      WM_CMP_START, WM_EEE_TWO, WM_FULL, WM_FULL, WM_FULL, WM_FULL,
      WM_PCS_CTRL_ONE};

   // ************************************************
   // Field positions
   // ************************************************
   localparam int CMP_START_W = 6;
   localparam int TXER_LPI_BIT = 14;
   localparam int TXER_PIN_LSB = 5;
   localparam int ADV_BYPASS_BIT = 3;
   localparam int NP_DISABLE_BIT = 2;
   localparam int RX_SHUT_BIT = 1;
   localparam int CAP_EN_BIT = 0;
   localparam int PCS_RESET_BIT = 15;
   localparam int RX_CLK_STOP_BIT = 10;
   localparam word_t CAP_EN_MASK = 16'h0001;
   localparam logic [CMP_START_W-1:0] CMP_START_RESET = 6'h0c;

   // Transmit-error pin routing codes
   typedef enum logic [1:0] {
      PIN_NONE = 2'h0,
      PIN_INTPD = 2'h1,
      PIN_COLGPIO = 2'h2,
      PIN_NONE_ALT = 2'h3
   } txer_pin_t;

   // Edges after reset release before the strap level is trusted
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

endpackage

// ===== design/cfg_word_reg.sv
/*
 * One 16-bit configuration word with per-bit write mask and reset value.
 * Assumes: synchronous soft clear and bit load from the owning bank.
 */
`timescale 1ns/1ps

module cfg_word_reg
   import phy_cfg_pkg::*;
#(
   parameter word_t RESET_VAL = '0,
   parameter word_t WR_MASK = '1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Update controls
   input wire logic soft_clr,
   input wire logic wr_en,
   input wire word_t wdata,
   input wire logic load_en,
   input wire word_t load_mask,
   input wire word_t load_val,
   // Stored value
   output word_t q
);

   word_t q_r;
   word_t q_nxt;
   word_t wr_val;
   word_t ld_val;

   // Read-only bits keep their reset value; loads win over writes
   assign wr_val = wr_en ? ((q_r & ~WR_MASK) | (wdata & WR_MASK)) : q_r;
   assign ld_val = (wr_val & ~load_mask) | (load_val & load_mask);
   assign q_nxt = soft_clr ? RESET_VAL : (load_en ? ld_val : wr_val);
   assign q = q_r;

   // Word storage
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_r <= RESET_VAL;
      end else begin
         q_r <= q_nxt;
      end
   end

endmodule // cfg_word_reg

// ===== design/phy_cfg_regs.sv
/*
 * Wake-pattern mask, EEE configuration and PCS control register bank.
 * Assumes: one clock, plain register port with read data one cycle later,
 * transmit-error and strap pins asynchronous, other inputs on ref_clk.
 */
`timescale 1ns/1ps

module phy_cfg_regs
   import phy_cfg_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Pins
   input wire logic eee_strap,
   input wire logic tx_err,
   // Link state from the PHY core
   input wire logic lpi_quiet,
   input wire logic lpi_active,
   input wire logic np_eee_adv,
   // Wake pattern controls
   output logic [63:16] pattern_byte_mask,
   output logic [CMP_START_W-1:0] compare_start,
   // EEE controls
   output logic tx_err_lpi_req,
   output logic tx_err_on_intpd,
   output logic tx_err_on_colgpio,
   output logic eee_adv_ability,
   output logic eee_np_refuse,
   output logic rx_analog_off,
   output logic eee_enabled,
   // Loop bandwidth trims
   output logic [DATA_W-1:0] loop_bw_one,
   output logic [DATA_W-1:0] loop_bw_two,
   output logic [DATA_W-1:0] loop_bw_three,
   // PCS controls
   output logic pcs_soft_reset,
   output logic rx_clk_stop_ok
);

   // ************************************************
   // Address decode
   // ************************************************

   // Index of the register at an address, and whether it exists
   function automatic logic [IDX_W:0] decode_addr(
      input logic [ADDR_W-1:0] a);
      logic [IDX_W:0] res;
      res = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (a == REG_OFFS[i]) begin
            res = {1'b1, IDX_W'(i)};
         end
      end
      return res;
   endfunction

   wire logic [IDX_W:0] dec;
   wire logic hit;
   wire logic [IDX_W-1:0] idx;
   assign dec = decode_addr(reg_addr);
   assign hit = dec[IDX_W];
   assign idx = dec[IDX_W-1:0];

   // ************************************************
   // Pin synchronisers
   // ************************************************
   logic strap_s1_r;
   logic strap_s2_r;
   logic txer_s1_r;
   logic txer_s2_r;

   // Both pins are asynchronous to ref_clk
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strap_s1_r <= 1'b0;
         strap_s2_r <= 1'b0;
         txer_s1_r <= 1'b0;
         txer_s2_r <= 1'b0;
      end else begin
         strap_s1_r <= eee_strap;
         strap_s2_r <= strap_s1_r;
         txer_s1_r <= tx_err;
         txer_s2_r <= txer_s1_r;
      end
   end

   // ************************************************
   // Strap capture
   // ************************************************
   logic [1:0] strap_cnt_r;
   logic strap_done_r;
   wire logic strap_load;

   // Strap sampled once, after the synchroniser has filled
   assign strap_load = !strap_done_r && (strap_cnt_r == STRAP_SETTLE);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strap_cnt_r <= '0;
         strap_done_r <= 1'b0;
      end else begin
         if (!strap_done_r && strap_cnt_r != STRAP_SETTLE) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
         end
         if (strap_load) begin
            strap_done_r <= 1'b1;
         end
      end
   end

   // ************************************************
   // PCS soft reset
   // ************************************************
   logic pcs_reset_r;
   wire logic pcs_reset_wr;

   // Self-clearing: high for exactly the cycle after the write
   assign pcs_reset_wr = reg_wr && hit && idx == IDX_W'(IDX_PCS_CTRL_ONE)
      && reg_wdata[PCS_RESET_BIT];

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pcs_reset_r <= 1'b0;
      end else begin
         pcs_reset_r <= pcs_reset_wr;
      end
   end

   // ************************************************
   // Register storage
   // ************************************************
   word_t regs [NUM_REGS];

   // Vendor words ignore the PCS reset; only the PCS word returns to
   // default, and a write in the reset cycle itself is lost
   generate
      for (genvar g = 0; g < NUM_REGS; g++) begin : g_word
         cfg_word_reg #(
            .RESET_VAL(REG_RSTS[g]),
            .WR_MASK(REG_WMS[g])
         ) u_word (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .soft_clr((g == IDX_PCS_CTRL_ONE) && pcs_reset_r),
            .wr_en(reg_wr && hit && idx == IDX_W'(g)),
            .wdata(reg_wdata),
            .load_en((g == IDX_EEE_THREE) && strap_load),
            .load_mask(CAP_EN_MASK),
            .load_val({{(DATA_W-1){1'b0}}, strap_s2_r}),
            .q(regs[g])
         );
      end
   endgenerate

   // ************************************************
   // Read port
   // ************************************************
   logic [DATA_W-1:0] rdata_r;
   wire word_t rd_word;

   // Reset bit reads its live self-clearing state; misses read zero
   assign rd_word = (idx == IDX_W'(IDX_PCS_CTRL_ONE))
      ? (regs[IDX_PCS_CTRL_ONE] | (word_t'(pcs_reset_r) << PCS_RESET_BIT))
      : regs[idx];

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= (reg_rd && hit) ? rd_word : '0;
      end
   end
   assign reg_rdata = rdata_r;

   // ************************************************
   // Field outputs
   // ************************************************
   wire word_t eee_two;
   wire word_t eee_three;
   wire txer_pin_t pin_sel;
   wire logic cap_en;

   assign eee_two = regs[IDX_EEE_TWO];
   assign eee_three = regs[IDX_EEE_THREE];
   assign pin_sel = txer_pin_t'(eee_two[TXER_PIN_LSB +: 2]);
   assign cap_en = eee_three[CAP_EN_BIT];

   // A set mask bit drops that byte from the comparison
   assign pattern_byte_mask = {regs[IDX_MASK_48_63],
      regs[IDX_MASK_32_47], regs[IDX_MASK_16_31]};
   assign compare_start =
      regs[IDX_CMP_START][CMP_START_W-1:0];

   // Transmit error qualifies as LPI request only when enabled
   assign tx_err_lpi_req = eee_two[TXER_LPI_BIT] && txer_s2_r;
   assign tx_err_on_intpd = tx_err_lpi_req
      && pin_sel == PIN_INTPD;
   assign tx_err_on_colgpio = tx_err_lpi_req
      && pin_sel == PIN_COLGPIO;

   // Next-page advertisement is ignored while EEE is disabled
   assign eee_adv_ability = eee_three[ADV_BYPASS_BIT] ? cap_en
      : (cap_en && np_eee_adv);
   assign eee_np_refuse = eee_three[NP_DISABLE_BIT];
   assign rx_analog_off = eee_three[RX_SHUT_BIT] && lpi_quiet;
   assign eee_enabled = cap_en;

   assign loop_bw_one = regs[IDX_LOOP_BW_ONE];
   assign loop_bw_two = regs[IDX_LOOP_BW_TWO];
   assign loop_bw_three = regs[IDX_LOOP_BW_THREE];

   // Receive clock may only stop while LPI is actually in force
   assign pcs_soft_reset = pcs_reset_r;
   assign rx_clk_stop_ok = regs[IDX_PCS_CTRL_ONE][RX_CLK_STOP_BIT]
      && lpi_active;

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   logic first_r;

   // Marks the first edge after reset release
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   sequence s_wr_at(word_t off);
      reg_wr && reg_addr == off;
   endsequence

   sequence s_pcs_reset_req;
      s_wr_at(OFF_PCS_CTRL_ONE) ##0 reg_wdata[PCS_RESET_BIT];
   endsequence

   a_mask_write: assert property (
      s_wr_at(OFF_MASK_32_47) |=> pattern_byte_mask[47:32] == $past(reg_wdata))
      else $error("byte mask word not updated by write");

   a_start_write: assert property (
      s_wr_at(OFF_CMP_START) |=>
      compare_start == $past(reg_wdata[CMP_START_W-1:0]))
      else $error("compare start field not updated by write");

   a_start_reset: assert property (
      first_r |-> compare_start == CMP_START_RESET
      && pattern_byte_mask == '0)
      else $error("compare start or masks wrong after reset");

   a_lpi_request: assert property (
      !eee_two[TXER_LPI_BIT] |-> !tx_err_lpi_req
      && !tx_err_on_intpd && !tx_err_on_colgpio)
      else $error("transmit error used while LPI request disabled");

   a_pin_route: assert property (
      (pin_sel == PIN_NONE || pin_sel == PIN_NONE_ALT)
      |-> !tx_err_on_intpd && !tx_err_on_colgpio)
      else $error("transmit error routed with no pin selected");

   a_adv_source: assert property (
      eee_three[ADV_BYPASS_BIT] |-> eee_adv_ability == cap_en)
      else $error("advertisement not taken from capability bit");

   a_adv_gated: assert property (
      !cap_en |-> !eee_adv_ability && !eee_enabled)
      else $error("EEE advertised while disabled");

   a_rx_shutdown: assert property (
      rx_analog_off |-> lpi_quiet && eee_three[RX_SHUT_BIT])
      else $error("analog receive off outside enabled quiet");

   a_pcs_selfclr: assert property (
      s_pcs_reset_req |=> pcs_soft_reset
      ##1 (!pcs_soft_reset && regs[IDX_PCS_CTRL_ONE] == RST_PCS_CTRL_ONE))
      else $error("PCS reset did not pulse once and restore defaults");

   a_vendor_kept: assert property (
      pcs_soft_reset && !reg_wr |=>
      $stable(regs[IDX_EEE_THREE][ADV_BYPASS_BIT:RX_SHUT_BIT])
      && $stable(loop_bw_one))
      else $error("PCS reset disturbed vendor registers");

   a_clk_stop: assert property (
      !regs[IDX_PCS_CTRL_ONE][RX_CLK_STOP_BIT] |-> !rx_clk_stop_ok)
      else $error("receive clock stop allowed while not stoppable");

   a_read_miss: assert property (
      reg_rd && !hit |=> reg_rdata == '0)
      else $error("unmapped read returned nonzero data");

endmodule // phy_cfg_regs

// ===== tb/testbench.sv
/*
 * Self-checking bench for the wake-pattern, EEE and PCS register bank.
 * Assumes: register port with read data one cycle after the read strobe.
 */
`timescale 1ns/1ps

module testbench;
   import phy_cfg_pkg::*;

   // ************************************************
   // Clock, reset and design signals
   // ************************************************
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = 16'h0000;
   logic [DATA_W-1:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic eee_strap = 1'b1;
   logic tx_err = 1'b0;
   logic lpi_quiet = 1'b0;
   logic lpi_active = 1'b0;
   logic np_eee_adv = 1'b0;
   wire [DATA_W-1:0] reg_rdata;
   wire [63:16] pattern_byte_mask;
   wire [CMP_START_W-1:0] compare_start;
   wire tx_err_lpi_req, tx_err_on_intpd, tx_err_on_colgpio;
   wire eee_adv_ability, eee_np_refuse, rx_analog_off, eee_enabled;
   wire [DATA_W-1:0] loop_bw_one, loop_bw_two, loop_bw_three;
   wire pcs_soft_reset, rx_clk_stop_ok;
   int failures = 0;
   int n_tests = 0;
   word_t exp_q[$];
   word_t v[NUM_REGS];
   logic rd_seen = 1'b0;
   logic q, n;

   phy_cfg_regs u_phy_cfg_regs (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eee_strap(eee_strap),
      .tx_err(tx_err), .lpi_quiet(lpi_quiet), .lpi_active(lpi_active),
      .np_eee_adv(np_eee_adv), .pattern_byte_mask(pattern_byte_mask),
      .compare_start(compare_start), .tx_err_lpi_req(tx_err_lpi_req),
      .tx_err_on_intpd(tx_err_on_intpd),
      .tx_err_on_colgpio(tx_err_on_colgpio),
      .eee_adv_ability(eee_adv_ability), .eee_np_refuse(eee_np_refuse),
      .rx_analog_off(rx_analog_off), .eee_enabled(eee_enabled),
      .loop_bw_one(loop_bw_one), .loop_bw_two(loop_bw_two),
      .loop_bw_three(loop_bw_three), .pcs_soft_reset(pcs_soft_reset),
      .rx_clk_stop_ok(rx_clk_stop_ok));

   // Free-running 25 MHz clock
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic check(input string what, input logic [47:0] seen,
                        input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One-cycle write; a gap cycle follows so strobes never collide
   task automatic wr(input word_t a, input word_t d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle read; expected word goes to the monitor's queue
   task automatic rd(input word_t a, input word_t e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe edge
   always @(posedge ref_clk) begin
      rd_seen <= reg_rd;
   end
   always @(negedge ref_clk) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected read", reg_rdata, 48'h0);
         end else begin
            check("read data", reg_rdata, exp_q.pop_front());
         end
      end
   end

   // Watchdog: a hung run counts as a mismatch
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      test_done();
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      void'($urandom(81));
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      // Reset values of the whole map
      for (int i = 0; i < NUM_REGS; i++) begin
         rd(REG_OFFS[i], REG_RSTS[i]);
      end
      @(negedge ref_clk);
      check("cmp start", compare_start, 48'hc);
      check("mask out", pattern_byte_mask, 48'h0);
      $display("test reset values done");

      // Fully writable words: masks and loop-bandwidth trims
      for (int i = 0; i < NUM_REGS; i++) begin
         v[i] = word_t'($urandom());
         if (REG_WMS[i] === WM_FULL && i != IDX_EEE_THREE) begin
            wr(REG_OFFS[i], v[i]);
            rd(REG_OFFS[i], v[i]);
         end
      end
      @(negedge ref_clk);
      check("mask out", pattern_byte_mask,
            {v[IDX_MASK_48_63], v[IDX_MASK_32_47], v[IDX_MASK_16_31]});
      check("loop bw", {loop_bw_three, loop_bw_two, loop_bw_one},
            {v[IDX_LOOP_BW_THREE], v[IDX_LOOP_BW_TWO], v[IDX_LOOP_BW_ONE]});
      $display("test rw words done");

      // Start field: upper bits read-only, boundary values
      wr(OFF_CMP_START, 16'hffc1);
      rd(OFF_CMP_START, 16'h0001);
      @(negedge ref_clk);
      check("cmp start", compare_start, 48'h1);
      wr(OFF_CMP_START, 16'h003f);
      @(negedge ref_clk);
      check("cmp start", compare_start, 48'h3f);
      wr(OFF_CMP_START, 16'h0000);
      @(negedge ref_clk);
      check("cmp start", compare_start, 48'h0);
      $display("test start field done");

      // Transmit-error routing for every pin code
      wr(OFF_EEE_TWO, 16'hffff);
      rd(OFF_EEE_TWO, 16'h4362);
      @(posedge ref_clk);
      tx_err <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(OFF_EEE_TWO, 16'h4000 | word_t'(c << 5));
         repeat (3) @(negedge ref_clk);
         check("lpi req", tx_err_lpi_req, 48'h1);
         check("on intpd", tx_err_on_intpd, 48'(c == 1));
         check("on colgpio", tx_err_on_colgpio, 48'(c == 2));
      end
      wr(OFF_EEE_TWO, 16'h0020);
      @(negedge ref_clk);
      check("lpi req", tx_err_lpi_req, 48'h0);
      check("on intpd", tx_err_on_intpd, 48'h0);
      $display("test tx error done");

      // Every combination of the four EEE control bits
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         q = 1'($urandom());
         n = 1'($urandom());
         lpi_quiet <= q;
         np_eee_adv <= n;
         v[IDX_EEE_THREE] = {12'($urandom()), 4'(i)};
         wr(OFF_EEE_THREE, v[IDX_EEE_THREE]);
         rd(OFF_EEE_THREE, v[IDX_EEE_THREE]);
         @(negedge ref_clk);
         check("adv", eee_adv_ability,
               48'(i[3] ? i[0] : (i[0] & n)));
         check("np refuse", eee_np_refuse, 48'(i[2]));
         check("rx off", rx_analog_off, 48'(i[1] & q));
         check("eee en", eee_enabled, 48'(i[0]));
      end
      $display("test eee controls done");

      // PCS soft reset pulse and clock-stoppable bit
      @(posedge ref_clk);
      lpi_active <= 1'b1;
      wr(OFF_PCS_CTRL_ONE, 16'h7bff);
      rd(OFF_PCS_CTRL_ONE, 16'h0000);
      wr(OFF_PCS_CTRL_ONE, 16'h0000);
      @(negedge ref_clk);
      check("clk stop", rx_clk_stop_ok, 48'h0);
      wr(OFF_PCS_CTRL_ONE, 16'h8000);
      @(negedge ref_clk);
      check("pcs pulse", pcs_soft_reset, 48'h1);
      @(negedge ref_clk);
      check("pcs pulse", pcs_soft_reset, 48'h0);
      check("clk stop", rx_clk_stop_ok, 48'h1);
      rd(OFF_PCS_CTRL_ONE, 16'h0400);
      rd(OFF_LOOP_BW_ONE, v[IDX_LOOP_BW_ONE]);
      rd(OFF_MASK_16_31, v[IDX_MASK_16_31]);
      $display("test pcs control done");

      // Unmapped offsets read zero and ignore writes
      wr(16'h04cd, 16'hffff);
      rd(16'h04cd, 16'h0000);
      rd(16'h04c8, 16'h0000);
      $display("test unmapped done");

      // Second reset with the strap low clears the capability bit
      @(posedge ref_clk);
      eee_strap <= 1'b0;
      sys_rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      check("eee en", eee_enabled, 48'h0);
      rd(OFF_EEE_THREE, 16'h018a);
      rd(OFF_MASK_48_63, 16'h0000);
      repeat (3) @(posedge ref_clk);
      $display("test strap done");
      test_done();
   end

endmodule // testbench
